// ### verilog/gpio_port_data_regs_abc.sv
// Port A, B and C data registers behind a classic Wishbone slave
`timescale 1ns/10ps
module gpio_port_data_regs_abc
    import gpio_port_pkg::*;
(
    input  wire logic              clk_in,            // System clock, 25 MHz
    input  wire logic              rst_b_in,          // Async reset, active low
    input  wire logic              ce_in,             // Clock enable, freezes state
    input  wire logic              wb_cyc_in,         // Wishbone cycle
    input  wire logic              wb_stb_in,         // Wishbone strobe
    input  wire logic              wb_we_in,          // Wishbone write enable
    input  wire logic [BUS_AW-1:0] wb_adr_in,         // Wishbone byte address
    input  wire logic [3:0]        wb_sel_in,         // Wishbone byte lanes
    input  wire logic [BUS_DW-1:0] wb_dat_in,         // Wishbone write data
    output logic      [BUS_DW-1:0] wb_dat_out,        // Wishbone read data
    output logic                   wb_ack_out,        // Wishbone acknowledge
    input  wire logic [PA_W-1:0]   port_a_pin_in,     // Port A pins 25..16
    input  wire logic [PA_W-1:0]   port_a_dir_in,     // Port A direction, 1 = out
    input  wire logic [PA_W-1:0]   port_a_gpio_sel_in,// Port A general port select
    output logic      [PA_W-1:0]   port_a_pin_out,    // Port A pin drive level
    output logic      [PA_W-1:0]   port_a_oe_out,     // Port A output enable
    input  wire logic [PB_W-1:0]   port_b_pin_in,     // Port B pins 13..0
    input  wire logic [PB_W-1:0]   port_b_dir_in,     // Port B direction, 1 = out
    input  wire logic [PB_W-1:0]   port_b_gpio_sel_in,// Port B general port select
    output logic      [PB_W-1:0]   port_b_pin_out,    // Port B pin drive level
    output logic      [PB_W-1:0]   port_b_oe_out,     // Port B output enable
    input  wire logic [PC_W-1:0]   port_c_pin_in,     // Port C pins 20..0
    input  wire logic [PC_W-1:0]   port_c_dir_in,     // Port C direction, 1 = out
    input  wire logic [PC_W-1:0]   port_c_gpio_sel_in,// Port C general port select
    output logic      [PC_W-1:0]   port_c_pin_out,    // Port C pin drive level
    output logic      [PC_W-1:0]   port_c_oe_out      // Port C output enable
);

    // Lane merge for the two low byte lanes of a 16-bit register
    function automatic logic [15:0] merge_bytes(
        input logic [15:0] old_v,
        input logic [15:0] new_v,
        input logic [1:0]  be
    );
        merge_bytes = {be[1] ? new_v[15:8] : old_v[15:8],
                       be[0] ? new_v[7:0]  : old_v[7:0]};
    endfunction

    // Pin level only for pins that are general port and input
    function automatic logic [15:0] read_pick(
        input logic [15:0] data_v,
        input logic [15:0] pin_v,
        input logic [15:0] dir_v,
        input logic [15:0] gsel_v
    );
        logic [15:0] use_pin;
        use_pin   = gsel_v & ~dir_v;
        read_pick = (data_v & ~use_pin) | (pin_v & use_pin);
    endfunction

    logic [PA_W-1:0]   pa_data_q;
    logic [PA_W-1:0]   pa_data_d;
    logic [PB_W-1:0]   pb_data_q;
    logic [PB_W-1:0]   pb_data_d;
    logic [PCH_W-1:0]  pch_data_q;
    logic [PCH_W-1:0]  pch_data_d;
    logic [PCL_W-1:0]  pcl_data_q;
    logic [PCL_W-1:0]  pcl_data_d;
    logic              ack_q;
    logic              ack_d;
    logic [BUS_DW-1:0] dat_q;
    logic [BUS_DW-1:0] dat_d;

    wire [PA_W-1:0] pa_sync_w;
    wire [PB_W-1:0] pb_sync_w;
    wire [PC_W-1:0] pc_sync_w;

    gpio_pin_sync #(.W(PA_W)) u_sync_a
    (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .ce_in    (ce_in),
        .pin_in   (port_a_pin_in),
        .sync_out (pa_sync_w)
    );

    gpio_pin_sync #(.W(PB_W)) u_sync_b
    (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .ce_in    (ce_in),
        .pin_in   (port_b_pin_in),
        .sync_out (pb_sync_w)
    );

    gpio_pin_sync #(.W(PC_W)) u_sync_c
    (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .ce_in    (ce_in),
        .pin_in   (port_c_pin_in),
        .sync_out (pc_sync_w)
    );

    // Bus decode
    wire        req_w    = wb_cyc_in & wb_stb_in & ~ack_q;
    wire [7:0]  adr_w    = {wb_adr_in[7:2], 2'b00};
    wire        hit_pa_w = adr_w == OFF_PA;
    wire        hit_pb_w = adr_w == OFF_PB;
    wire        hit_pch_w = adr_w == OFF_PCH;
    wire        hit_pcl_w = adr_w == OFF_PCL;
    wire        wr_w     = req_w & wb_we_in;
    wire [15:0] wr_word_w = wb_dat_in[15:0];
    wire [1:0]  be_w     = wb_sel_in[1:0];

    // Upper bits of the A, B and C high merges are dropped: reserved bits keep no state
    wire [15:0] pa_merge_w  = merge_bytes(16'(pa_data_q), wr_word_w, be_w);
    wire [15:0] pb_merge_w  = merge_bytes(16'(pb_data_q), wr_word_w, be_w);
    wire [15:0] pch_merge_w = merge_bytes(16'(pch_data_q), wr_word_w, be_w);
    wire [15:0] pcl_merge_w = merge_bytes(pcl_data_q, wr_word_w, be_w);

    // Writes always store, whatever the pin function
    assign pa_data_d  = (wr_w & hit_pa_w)  ? pa_merge_w[PA_W-1:0]   : pa_data_q;
    assign pb_data_d  = (wr_w & hit_pb_w)  ? pb_merge_w[PB_W-1:0]   : pb_data_q;
    assign pch_data_d = (wr_w & hit_pch_w) ? pch_merge_w[PCH_W-1:0] : pch_data_q;
    assign pcl_data_d = (wr_w & hit_pcl_w) ? pcl_merge_w            : pcl_data_q;

    // Read selection per bit, driven by the pin function controller view
    wire [15:0] pa_rd_w  = read_pick(16'(pa_data_q), 16'(pa_sync_w),
                                     16'(port_a_dir_in), 16'(port_a_gpio_sel_in));
    wire [15:0] pb_rd_w  = read_pick(16'(pb_data_q), 16'(pb_sync_w),
                                     16'(port_b_dir_in), 16'(port_b_gpio_sel_in));
    wire [15:0] pch_rd_w = read_pick(16'(pch_data_q), 16'(pc_sync_w[PC_W-1:PCL_W]),
                                     16'(port_c_dir_in[PC_W-1:PCL_W]),
                                     16'(port_c_gpio_sel_in[PC_W-1:PCL_W]));
    wire [15:0] pcl_rd_w = read_pick(pcl_data_q, pc_sync_w[PCL_W-1:0],
                                     port_c_dir_in[PCL_W-1:0],
                                     port_c_gpio_sel_in[PCL_W-1:0]);

    // Unmapped words read as zero and still acknowledge
    wire [15:0] rd_mux_w = hit_pa_w  ? pa_rd_w  :
                           hit_pb_w  ? pb_rd_w  :
                           hit_pch_w ? pch_rd_w :
                           hit_pcl_w ? pcl_rd_w : DATA_RESET;

    assign ack_d = req_w;
    assign dat_d = req_w ? {16'h0000, rd_mux_w} : dat_q;

    // Drive only general port pins whose direction bit is one
    wire [PA_W-1:0] pa_drive_w = port_a_gpio_sel_in & port_a_dir_in;
    wire [PB_W-1:0] pb_drive_w = port_b_gpio_sel_in & port_b_dir_in;
    wire [PC_W-1:0] pc_drive_w = port_c_gpio_sel_in & port_c_dir_in;
    wire [PC_W-1:0] pc_data_w  = {pch_data_q, pcl_data_q};

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pa_data_q  <= DATA_RESET[PA_W-1:0];
            pb_data_q  <= DATA_RESET[PB_W-1:0];
            pch_data_q <= DATA_RESET[PCH_W-1:0];
            pcl_data_q <= DATA_RESET;
        end
        else if (ce_in)
        begin
            pa_data_q  <= pa_data_d;
            pb_data_q  <= pb_data_d;
            pch_data_q <= pch_data_d;
            pcl_data_q <= pcl_data_d;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            ack_q <= 1'b0;
            dat_q <= BUS_ZERO;
        end
        else if (ce_in)
        begin
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    // Pin drive is registered, so it trails the data register by one cycle
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            port_a_pin_out <= '0;
            port_a_oe_out  <= '0;
            port_b_pin_out <= '0;
            port_b_oe_out  <= '0;
            port_c_pin_out <= '0;
            port_c_oe_out  <= '0;
        end
        else if (ce_in)
        begin
            port_a_pin_out <= pa_data_q;
            port_a_oe_out  <= pa_drive_w;
            port_b_pin_out <= pb_data_q;
            port_b_oe_out  <= pb_drive_w;
            port_c_pin_out <= pc_data_w;
            port_c_oe_out  <= pc_drive_w;
        end
    end

    assign wb_ack_out = ack_q;
    assign wb_dat_out = dat_q;

    chk_a_drive_enable: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        ce_in |=> port_a_oe_out == $past(pa_drive_w))
        else $error("Port A output enable does not follow selection and direction");

    chk_a_drive_level: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        ce_in |=> port_a_pin_out == $past(pa_data_q))
        else $error("Port A drive level differs from stored data");

    chk_a_read_pick: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (ce_in && req_w && !wb_we_in && hit_pa_w)
        |=> wb_dat_out[PA_W-1:0] == (($past(pa_sync_w) & $past(port_a_gpio_sel_in) & ~$past(port_a_dir_in))
            | ($past(pa_data_q) & ~($past(port_a_gpio_sel_in) & ~$past(port_a_dir_in)))))
        else $error("Port A read data is not the selected source");

    chk_b_output_readback: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (ce_in && req_w && !wb_we_in && hit_pb_w && (&pb_drive_w))
        |=> wb_dat_out[PB_W-1:0] == $past(pb_data_q))
        else $error("Port B output pins did not read back stored data");

    chk_resv_read_zero: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (wb_ack_out && hit_pa_w) |-> wb_dat_out[31:PA_W] == '0)
        else $error("Reserved bits of port A read nonzero");

    chk_b_input_undriven: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (ce_in && pb_drive_w == '0) |=> port_b_oe_out == '0)
        else $error("Port B drives a pin that is not general output");

    chk_c_low_write: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (ce_in && wr_w && hit_pcl_w && be_w == 2'b11) |=> pcl_data_q == $past(wr_word_w))
        else $error("Port C low register did not store the written word");

    chk_c_drive_enable: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        ce_in |=> port_c_oe_out == $past(pc_drive_w))
        else $error("Port C drives a pin not selected as general output");

    chk_sync_two_stage: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        ce_in ##1 ce_in |=> pc_sync_w == $past(port_c_pin_in, 2))
        else $error("Port C pin sample latency is not two cycles");

    chk_ack_single: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        wb_ack_out |=> !wb_ack_out)
        else $error("Acknowledge held longer than one cycle");

    // Pin drive and read masking seen from the ports; write storage and reset clearing on the data registers

    chk_b_drive_enable: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        ce_in |=> port_b_oe_out == ($past(port_b_gpio_sel_in) & $past(port_b_dir_in)))
        else $error("Port B output enable does not follow selection and direction");

    chk_b_drive_level: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        ce_in |=> port_b_pin_out == $past(pb_data_q))
        else $error("Port B drive level differs from stored data");

    chk_c_drive_level: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        ce_in |=> port_c_pin_out == {$past(pch_data_q), $past(pcl_data_q)})
        else $error("Port C drive level differs from the two stored halves");

    chk_b_resv_zero: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (wb_ack_out && hit_pb_w) |-> wb_dat_out[31:PB_W] == '0)
        else $error("Reserved bits of port B read nonzero");

    chk_ch_resv_zero: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (wb_ack_out && hit_pch_w) |-> wb_dat_out[31:PCH_W] == '0)
        else $error("Reserved bits of port C high read nonzero");

    chk_upper_half_zero: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        wb_ack_out |-> wb_dat_out[31:16] == '0)
        else $error("Upper half of the read word is nonzero");

    chk_a_write_store: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (ce_in && wr_w && hit_pa_w && be_w == 2'b11) |=> pa_data_q == $past(wr_word_w[PA_W-1:0]))
        else $error("Port A register did not store the written bits");

    chk_reset_clear: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        $rose(rst_b_in) |-> (pa_data_q == '0 && pb_data_q == '0 && pch_data_q == '0 && pcl_data_q == '0))
        else $error("Data registers not cleared by reset");

endmodule

// ### verilog/gpio_port_pkg.sv
// Constants for the port A/B/C data register block
package gpio_port_pkg;

    localparam int          REG_W      = 16;
    localparam int          BUS_DW     = 32;
    localparam int          BUS_AW     = 8;
    localparam int          PA_W       = 10;
    localparam int          PB_W       = 14;
    localparam int          PCH_W      = 5;
    localparam int          PCL_W      = 16;
    localparam int          PC_W       = PCH_W + PCL_W;

    localparam logic [7:0]  OFF_PA     = 8'h00;
    localparam logic [7:0]  OFF_PB     = 8'h04;
    localparam logic [7:0]  OFF_PCH    = 8'h08;
    localparam logic [7:0]  OFF_PCL    = 8'h0c;

    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [31:0] BUS_ZERO   = 32'h0000_0000;
    localparam int          SYNC_DEPTH = 2;

endpackage

// ### verilog/gpio_pin_sync.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module gpio_pin_sync
    import gpio_port_pkg::*;
#(
    parameter int W = 1
)
(
    input  wire logic         clk_in,   // System clock
    input  wire logic         rst_b_in, // Async reset, active low
    input  wire logic         ce_in,    // Clock enable
    input  wire logic [W-1:0] pin_in,   // Raw pin levels
    output logic      [W-1:0] sync_out  // Synchronised levels
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else if (ce_in)
        begin
            meta_q   <= pin_in;
            sync_out <= meta_q;
        end
    end

endmodule

// ### verification/gpio_pin_model.sv
// External pin model: port drive where enabled, outside driver elsewhere
`timescale 1ns/10ps
module gpio_pin_model
#(
    parameter int W = 45
)
(
    input  wire logic [W-1:0] oe_in,   // Block output enables
    input  wire logic [W-1:0] drv_in,  // Block drive levels
    input  wire logic [W-1:0] ext_in,  // Outside driver levels
    output logic      [W-1:0] lvl_out  // Resolved pin levels
);
    // Outside driver backs off wherever the block drives
    assign lvl_out = (oe_in & drv_in) | (~oe_in & ext_in);
endmodule

// ### verification/gpio_port_data_regs_abc_tb.sv
// Self-checking bench for the port A/B/C data registers
`timescale 1ns/10ps
module gpio_port_data_regs_abc_tb;
    import gpio_port_pkg::*;
    logic        clk_in;
    logic        rst_b_in;
    logic        ce_in;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
    wire  [31:0] rdat;
    wire         ack;
    logic [44:0] gs;
    logic [44:0] dr;
    logic [44:0] ext;
    logic [44:0] st;
    wire  [44:0] oe_all;
    wire  [44:0] po_all;
    wire  [44:0] lvl;
    logic [15:0] q;
    logic [7:0]  offs [4] = '{OFF_PA, OFF_PB, OFF_PCH, OFF_PCL};
    int          failures = 0;
    int          comparisons = 0;

    gpio_port_data_regs_abc gpio_port_data_regs_abc_inst (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .port_a_pin_in(lvl[9:0]), .port_a_dir_in(dr[9:0]), .port_a_gpio_sel_in(gs[9:0]),
        .port_a_pin_out(po_all[9:0]), .port_a_oe_out(oe_all[9:0]),
        .port_b_pin_in(lvl[23:10]), .port_b_dir_in(dr[23:10]), .port_b_gpio_sel_in(gs[23:10]),
        .port_b_pin_out(po_all[23:10]), .port_b_oe_out(oe_all[23:10]),
        .port_c_pin_in(lvl[44:24]), .port_c_dir_in(dr[44:24]), .port_c_gpio_sel_in(gs[44:24]),
        .port_c_pin_out(po_all[44:24]), .port_c_oe_out(oe_all[44:24]));

    gpio_pin_model #(.W(45)) gpio_pin_model_inst (
        .oe_in(oe_all), .drv_in(po_all), .ext_in(ext), .lvl_out(lvl));

    initial
    begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    function automatic logic [15:0] view(input int i, input logic [44:0] v);
        case (i)
            0: view = {6'h00, v[9:0]};
            1: view = {2'h0, v[23:10]};
            2: view = {11'h000, v[44:40]};
            default: view = v[39:24];
        endcase
    endfunction

    task automatic chk(input logic [44:0] g, input logic [44:0] e);
        comparisons++;
        if (g !== e)
        begin
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
            failures++;
        end
    endtask

    // Classic cycle; waits for ack, then idles one cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
        int n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        sel <= s;
        dat <= {16'hffff, d};
        do
        begin
            @(posedge clk_in);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            failures++;
            wrap_up();
        end
        q = rdat[15:0];
        if (!w) chk(45'(rdat[31:16]), 45'h0);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic wr(input int i, input logic [15:0] d, input logic [3:0] s);
        logic [15:0] m;
        logic [15:0] nv;
        m  = {{8{s[1]}}, {8{s[0]}}};
        nv = (view(i, st) & ~m) | (d & m);
        bus(1'b1, offs[i], d, s);
        case (i)
            0: st[9:0] = nv[9:0];
            1: st[23:10] = nv[13:0];
            2: st[44:40] = nv[4:0];
            default: st[39:24] = nv;
        endcase
    endtask

    // General port input pins read the outside level, all others the stored bit
    task automatic rdall();
        logic [44:0] ev;
        ev = (gs & ~dr & ext) | (~(gs & ~dr) & st);
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b0, offs[i], 16'h0000, 4'h0);
            chk(45'(q), 45'(view(i, ev)));
        end
    endtask

    task automatic pchk(input int t);
        repeat (4) @(posedge clk_in);
        chk(oe_all, gs & dr);
        chk(po_all, st);
        $display("test %0d done", t);
    endtask

    task automatic wrall(input logic [15:0] d);
        for (int i = 0; i < 4; i++) wr(i, d, 4'h3);
    endtask

    task automatic wrap_up();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        #(40 * 5000);
        failures++;
        wrap_up();
    end

    initial
    begin
        {cyc, stb, we, adr, sel, dat} = '0;
        ce_in = 1'b1;
        st  = '0;
        gs  = '0;
        dr  = '0;
        ext = 45'h0a5a_f0f0_3c3c;
        rst_b_in = 1'b0;
        repeat (20) @(posedge clk_in);
        rst_b_in <= 1'b1;
        @(posedge clk_in);
        rdall();
        pchk(1);
        gs <= '1;
        dr <= '1;
        wrall(16'hffff);
        rdall();
        wr(1, 16'h1234, 4'h1);
        wr(3, 16'h9876, 4'h2);
        rdall();
        pchk(2);
        dr <= '0;
        repeat (4) @(posedge clk_in);
        rdall();
        wrall(16'h0000);
        rdall();
        pchk(3);
        gs <= '0;
        dr <= '1;
        wrall(16'hc3a5);
        rdall();
        pchk(4);
        gs  <= 45'h0aaa_aaaa_aaaa;
        dr  <= 45'h0ccc_cccc_cccc;
        ext <= ~st;
        repeat (4) @(posedge clk_in);
        rdall();
        pchk(5);
        bus(1'b1, 8'h14, 16'hffff, 4'h3);
        bus(1'b0, 8'h14, 16'h0000, 4'h0);
        chk(45'(q), 45'h0);
        rdall();
        pchk(6);
        // Clock enable low must hold the old drive enables
        ce_in <= 1'b0;
        gs    <= ~gs;
        repeat (4) @(posedge clk_in);
        chk(oe_all, ~gs & dr);
        ce_in <= 1'b1;
        pchk(7);
        rst_b_in <= 1'b0;
        st = '0;
        repeat (2) @(posedge clk_in);
        rst_b_in <= 1'b1;
        // Sync stages refill before input pins are read
        repeat (4) @(posedge clk_in);
        rdall();
        pchk(8);
        wrap_up();
    end
endmodule
